// File: logic/ctb_pkg.sv
// Behaviour
// - dedicated buffers sit first in the section, fifo/queue elements follow directly.
// - element kind follows from dedicated count alone; fifo/queue size only bounds the valid indexes.
// - software sets element data size, up to 64-byte fd data fields.
// - header word 0 bit 31 is esi; 0 follows error passive, 1 recessive.
// - sent esi is element esi or'ed with the node error passive flag.
// - header word 0 bit 30 picks 11-bit standard or 29-bit extended identifier.
// - header word 0 bit 29 picks data frame or remote frame.
// - a remote request always goes out in classic format, fd enable ignored.
// - 8-bit message marker from word 1 bits 31:24 goes into the event entry.
// - one cancel-finished interrupt enable bit per buffer, bit x for buffer x.
// - enable bit 0 disables, 1 enables; register resets to all zeros.
package ctb_pkg;
    localparam int unsigned ADDR_W          = 13;
    localparam int unsigned BUF_COUNT       = 32;
    localparam int unsigned IDX_W           = 5;
    localparam int unsigned WORD_ADDR_W     = 10;
    localparam int unsigned HDR_WORDS       = 2;
    localparam int unsigned MAX_DATA_WORDS  = 16;
    localparam int unsigned CLASSIC_BYTES   = 8;

    // register byte addresses
    localparam logic [12:0] REG_TX_BUFFER_CONFIG       = 13'h0c0;
    localparam logic [12:0] REG_TX_ELEMENT_SIZE_CONFIG = 13'h0c8;
    localparam logic [12:0] REG_CONTROL                = 13'h0cc;
    localparam logic [12:0] REG_TX_REQUEST             = 13'h0d0;
    localparam logic [12:0] REG_TX_CANCEL              = 13'h0d4;
    localparam logic [12:0] REG_STATUS                 = 13'h0d8;
    localparam logic [12:0] REG_CANCEL_DONE            = 13'h0dc;
    localparam logic [12:0] REG_TX_CANCEL_IRQ_ENABLE   = 13'h0e4;
    localparam int unsigned RAM_SEL_BIT                = 12;

    // reset values
    localparam logic [31:0] TX_CANCEL_IRQ_ENABLE_RESET = 32'h0000_0000;
    localparam logic [5:0]  CONFIG_RESET               = 6'h00;
    localparam logic [2:0]  ESIZE_RESET                = 3'h0;

    // config field positions
    localparam int unsigned CFG_DEDICATED_TX_BUFFER_COUNT_LO = 0;
    localparam int unsigned CFG_TX_FIFO_QUEUE_SIZE_LO = 8;
    localparam int unsigned CTRL_FD_OPERATION_ENABLE   = 0;
    localparam int unsigned STAT_BUSY   = 8;
    localparam int unsigned STAT_REFUSE = 9;

    // header word 0 / word 1 field positions
    localparam int unsigned T0_ESI    = 31;
    localparam int unsigned T0_XTD    = 30;
    localparam int unsigned T0_RTR    = 29;
    localparam int unsigned T0_ID_HI  = 28;
    localparam int unsigned T0_STD_LO = 18;
    localparam int unsigned T1_MM_LO  = 24;
    localparam int unsigned T1_EFC    = 23;
    localparam int unsigned T1_FDF    = 21;
    localparam int unsigned T1_BRS    = 20;
    localparam int unsigned T1_DLC_LO = 16;

    typedef struct packed {
        logic [4:0]  index;
        logic        is_fifo_queue;
        logic        esi;
        logic        extended;
        logic        remote;
        logic [28:0] id;
        logic        fd_format;
        logic        brs;
        logic [3:0]  dlc;
        logic        efc;
        logic [7:0]  marker;
    } ctb_frame_type;

    typedef struct packed {
        logic [7:0] marker;
        logic [4:0] index;
    } ctb_event_type;
endpackage : ctb_pkg

// File: logic/ctb_tx_element.sv
// plain fifo between element reader and protocol engine
//
// Design decision made here: the address-and-strobe port.
module ctb_fifo
    import ctb_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign do_push   = in_valid && in_ready && !flush;
    assign do_pop    = out_valid && out_ready && !flush;

    // storage, no reset needed on data
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end
endmodule : ctb_fifo

module ctb_tx_element
    import ctb_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8,
    parameter int unsigned RAM_WORDS  = BUF_COUNT * (HDR_WORDS + MAX_DATA_WORDS)
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic [12:0]   reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_write,
    input  wire logic          reg_read,
    output logic      [31:0]   reg_rdata,
    input  wire logic          error_passive,
    output ctb_frame_type      frame_desc,
    output logic               frame_valid,
    input  wire logic          frame_done,
    output logic      [31:0]   payload_data,
    output logic               payload_valid,
    input  wire logic          payload_ready,
    output ctb_event_type      event_entry,
    output logic               event_valid,
    output logic               cancel_irq
);
    typedef enum logic [2:0] {ST_IDLE, ST_HDR0, ST_HDR1, ST_PUSH, ST_WAIT} ctb_state_type;

    logic [31:0]            ram [RAM_WORDS];
    ctb_state_type          state;
    logic [5:0]             dedicated_tx_buffer_count;
    logic [5:0]             tx_fifo_queue_size;
    logic [2:0]             tx_element_size_config;
    logic                   fd_operation_enable;
    logic [31:0]            tx_cancel_irq_enable_reg;
    logic [31:0]            cancel_done;
    logic                   refused;
    logic [4:0]             active_index;
    logic [WORD_ADDR_W-1:0] word_ptr;
    logic [4:0]             words_left;
    logic [31:0]            ram_word;
    logic                   fifo_in_ready;
    logic                   fifo_push;
    logic                   fifo_flush;
    logic [31:0]            fifo_out_data;
    logic                   fifo_out_valid;
    logic                   ram_sel;
    logic                   req_write;
    logic                   cancel_write;
    logic [4:0]             wr_index;
    logic                   cancel_hit;
    logic                   req_ok;

    // payload bytes for a dlc code, fd codes above 8 step up to 64
    function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
        logic [6:0] b;
        b = 7'h00;
        unique case (dlc)
            4'h9:    b = 7'h0c;
            4'ha:    b = 7'h10;
            4'hb:    b = 7'h14;
            4'hc:    b = 7'h18;
            4'hd:    b = 7'h20;
            4'he:    b = 7'h30;
            4'hf:    b = 7'h40;
            default: b = {3'h0, dlc};
        endcase
        return b;
    endfunction : dlc_bytes

    // data words an element holds for a size code: 8,12,16,20,24,32,48,64 bytes
    function automatic logic [4:0] esize_words(input logic [2:0] code);
        logic [4:0] w;
        w = 5'h00;
        unique case (code)
            3'h5:    w = 5'h08;
            3'h6:    w = 5'h0c;
            3'h7:    w = 5'h10;
            default: w = 5'(code) + 5'h02;
        endcase
        return w;
    endfunction : esize_words

    // first word of element idx; dedicated buffers first, fifo/queue right after
    function automatic logic [WORD_ADDR_W-1:0] element_base(input logic [4:0] idx, input logic [2:0] code);
        logic [WORD_ADDR_W-1:0] stride;
        stride = WORD_ADDR_W'(esize_words(code)) + WORD_ADDR_W'(HDR_WORDS);
        return WORD_ADDR_W'(WORD_ADDR_W'(idx) * stride);
    endfunction : element_base

    assign ram_sel      = reg_addr[RAM_SEL_BIT];
    assign req_write    = reg_write && !ram_sel && (reg_addr == REG_TX_REQUEST);
    assign cancel_write = reg_write && !ram_sel && (reg_addr == REG_TX_CANCEL);
    assign wr_index     = reg_wdata[IDX_W-1:0];
    assign cancel_hit   = cancel_write && (state != ST_IDLE) && (wr_index == active_index);
    // index must lie inside dedicated plus fifo/queue elements
    // sum kept at seven bits so two large counts cannot wrap to zero
    assign req_ok       = (state == ST_IDLE) &&
                          ({2'b00, wr_index} < (7'(dedicated_tx_buffer_count) + 7'(tx_fifo_queue_size)));
    assign ram_word     = ram[word_ptr];
    assign fifo_push    = (state == ST_PUSH) && (words_left != '0);
    assign fifo_flush   = cancel_hit;

    // software side of the element section
    always_ff @(posedge sys_clk) begin
        if (reg_write && ram_sel) begin
            ram[reg_addr[WORD_ADDR_W+1:2]] <= reg_wdata;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dedicated_tx_buffer_count <= CONFIG_RESET;
            tx_fifo_queue_size        <= CONFIG_RESET;
            tx_element_size_config    <= ESIZE_RESET;
            fd_operation_enable       <= 1'b0;
        end else if (reg_write && !ram_sel) begin
            if (reg_addr == REG_TX_BUFFER_CONFIG) begin
                dedicated_tx_buffer_count <= reg_wdata[CFG_DEDICATED_TX_BUFFER_COUNT_LO +: 6];
                tx_fifo_queue_size        <= reg_wdata[CFG_TX_FIFO_QUEUE_SIZE_LO +: 6];
            end
            // element data size, largest code holds 64 bytes
            if (reg_addr == REG_TX_ELEMENT_SIZE_CONFIG) begin
                tx_element_size_config <= reg_wdata[2:0];
            end
            if (reg_addr == REG_CONTROL) begin
                fd_operation_enable <= reg_wdata[CTRL_FD_OPERATION_ENABLE];
            end
        end
    end

    // one enable bit per buffer, zero after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cancel_irq_enable_reg <= TX_CANCEL_IRQ_ENABLE_RESET;
        end else if (reg_write && !ram_sel && reg_addr == REG_TX_CANCEL_IRQ_ENABLE) begin
            tx_cancel_irq_enable_reg <= reg_wdata;
        end
    end

    // cancel finished flags; a new cancel beats a write-one clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cancel_done <= '0;
        end else begin
            cancel_done <= (cancel_done & ~((reg_write && !ram_sel && reg_addr == REG_CANCEL_DONE) ? reg_wdata : '0))
                         | (cancel_write ? (32'h0000_0001 << wr_index) : '0);
        end
    end

    // interrupt from finished cancels that are enabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cancel_irq <= 1'b0;
        end else begin
            cancel_irq <= |(cancel_done & tx_cancel_irq_enable_reg);
        end
    end

    // refused requests leave the busy element untouched
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (req_write) begin
            refused <= !req_ok;
        end
    end

    // element reader walking header then payload
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            active_index <= '0;
            word_ptr     <= '0;
            words_left   <= '0;
            frame_desc   <= '0;
            frame_valid  <= 1'b0;
        end else if (cancel_hit) begin
            // abort drops the frame; no event is made for it
            state       <= ST_IDLE;
            frame_valid <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (req_write && req_ok) begin
                        // element address from the shared section layout
                        active_index <= wr_index;
                        word_ptr     <= element_base(wr_index, tx_element_size_config);
                        state        <= ST_HDR0;
                    end
                end
                ST_HDR0: begin
                    frame_desc.index <= active_index;
                    // beyond the dedicated ones it is a fifo/queue element
                    frame_desc.is_fifo_queue <= ({1'b0, active_index} >= dedicated_tx_buffer_count);
                    // esi sent recessive if element asks or node is error passive
                    frame_desc.esi <= ram_word[T0_ESI] | error_passive;
                    // standard id taken from 28:18, low bits cleared
                    frame_desc.extended <= ram_word[T0_XTD];
                    frame_desc.id <= ram_word[T0_XTD] ? ram_word[T0_ID_HI:0]
                                   : {ram_word[T0_ID_HI:T0_STD_LO], 18'h00000};
                    frame_desc.remote <= ram_word[T0_RTR];
                    word_ptr <= word_ptr + 1'b1;
                    state    <= ST_HDR1;
                end
                ST_HDR1: begin
                    // remote frames forced classic whatever fd enable says
                    // control bits and dlc read from the second header word
                    frame_desc.fd_format <= ram_word[T1_FDF] && fd_operation_enable && !frame_desc.remote;
                    frame_desc.brs       <= ram_word[T1_BRS] && ram_word[T1_FDF] && fd_operation_enable
                                            && !frame_desc.remote;
                    frame_desc.dlc       <= ram_word[T1_DLC_LO +: 4];
                    frame_desc.efc       <= ram_word[T1_EFC];
                    frame_desc.marker    <= ram_word[T1_MM_LO +: 8];
                    words_left <= next_words(ram_word);
                    word_ptr   <= word_ptr + 1'b1;
                    frame_valid <= 1'b1;
                    state      <= ST_PUSH;
                end
                ST_PUSH: begin
                    // payload words in ascending order, raw byte lanes
                    if (words_left == '0) begin
                        state <= ST_WAIT;
                    end else if (fifo_in_ready) begin
                        word_ptr   <= word_ptr + 1'b1;
                        words_left <= words_left - 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (frame_done) begin
                        frame_valid <= 1'b0;
                        state       <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // payload length: remote none, classic capped at 8, never beyond the element
    function automatic logic [4:0] next_words(input logic [31:0] t1);
        logic [6:0] bytes;
        logic [4:0] words;
        bytes = dlc_bytes(t1[T1_DLC_LO +: 4]);
        if (frame_desc.remote) begin
            bytes = 7'h00;
        end else if (!(t1[T1_FDF] && fd_operation_enable) && bytes > 7'(CLASSIC_BYTES)) begin
            bytes = 7'(CLASSIC_BYTES);
        end
        words = 5'((bytes + 7'h03) >> 2);
        if (words > esize_words(tx_element_size_config)) begin
            words = esize_words(tx_element_size_config);
        end
        return words;
    endfunction : next_words

    // event entry carries the marker of the finished frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_entry <= '0;
            event_valid <= 1'b0;
        end else begin
            event_valid <= (state == ST_WAIT) && frame_done && frame_desc.efc && !cancel_hit;
            if ((state == ST_WAIT) && frame_done) begin
                event_entry.marker <= frame_desc.marker;
                event_entry.index  <= frame_desc.index;
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            if (ram_sel) begin
                reg_rdata <= ram[reg_addr[WORD_ADDR_W+1:2]];
            end else begin
                unique case (reg_addr)
                    REG_TX_BUFFER_CONFIG:       reg_rdata <= {18'h0, tx_fifo_queue_size, 2'h0,
                                                              dedicated_tx_buffer_count};
                    REG_TX_ELEMENT_SIZE_CONFIG: reg_rdata <= {29'h0, tx_element_size_config};
                    REG_CONTROL:                reg_rdata <= {31'h0, fd_operation_enable};
                    REG_STATUS:                 reg_rdata <= {22'h0, refused, state != ST_IDLE, 3'h0, active_index};
                    REG_CANCEL_DONE:            reg_rdata <= cancel_done;
                    REG_TX_CANCEL_IRQ_ENABLE:   reg_rdata <= tx_cancel_irq_enable_reg;
                    default:                    reg_rdata <= '0;
                endcase
            end
        end
    end

    ctb_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (fifo_flush),
        .in_data   (ram_word),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (payload_ready)
    );
    assign payload_data  = fifo_out_data;
    assign payload_valid = fifo_out_valid;

    sequence req_taken;
        req_write && req_ok;
    endsequence
    sequence hdr_read;
        (state == ST_HDR0) ##1 (state == ST_HDR1);
    endsequence

    req_walk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_taken ##1 !cancel_hit |-> hdr_read ##1 (frame_valid || $past(cancel_hit)))
        else $error("request did not walk the header");
    esi_or_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == ST_HDR0) && error_passive && !cancel_hit |=> frame_desc.esi)
        else $error("error passive node sent esi dominant");
    remote_classic_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_valid && frame_desc.remote |-> !frame_desc.fd_format && !frame_desc.brs)
        else $error("remote frame went out in fd format");
    classify_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(frame_valid) |-> frame_desc.is_fifo_queue == ({1'b0, frame_desc.index} >= dedicated_tx_buffer_count))
        else $error("element kind wrong");
    std_id_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_valid && !frame_desc.extended |-> frame_desc.id[T0_STD_LO-1:0] == '0)
        else $error("standard id not at 28:18");
    enable_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && !ram_sel && reg_addr == REG_TX_CANCEL_IRQ_ENABLE |=> tx_cancel_irq_enable_reg == $past(reg_wdata))
        else $error("enable register not written");
    cancel_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cancel_write && tx_cancel_irq_enable_reg[wr_index] |=> ##1 cancel_irq)
        else $error("enabled cancel gave no interrupt");
    marker_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        event_valid |-> event_entry.marker == frame_desc.marker && event_entry.index == frame_desc.index)
        else $error("event marker mismatch");
endmodule : ctb_tx_element

// File: verif/ctb_engine_model.sv
module ctb_engine_model
    import ctb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        frame_valid,
    input  wire logic [31:0] payload_data,
    input  wire logic        payload_valid,
    input  wire logic [4:0]  want,
    output logic             payload_ready,
    output logic             frame_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        stall;
    logic [31:0] got[$];

    // pops only every other cycle, so the fifo backs up behind it
    assign payload_ready = ~stall;

    // keep pulsing done while the expected word count is in; an early one is just ignored
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stall      <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            stall <= ~stall;
            if (payload_valid && payload_ready)
                got.push_back(payload_data);
            frame_done <= frame_valid && (got.size() == int'(want)) && !frame_done;
        end
    end
endmodule : ctb_engine_model

// File: verif/tb.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb
    import ctb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          sys_clk, rst_n, reg_write, reg_read, error_passive;
    logic          frame_valid, frame_done, payload_valid, payload_ready, event_valid, cancel_irq;
    logic [12:0]   reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, payload_data, rv;
    logic [4:0]    want;
    ctb_frame_type frame_desc, exp_f;
    ctb_event_type event_entry, ev;
    int            err_count = 0;
    int            compares = 0;
    int            ev_count = 0;

    ctb_tx_element dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .error_passive(error_passive),
        .frame_desc(frame_desc), .frame_valid(frame_valid), .frame_done(frame_done),
        .payload_data(payload_data), .payload_valid(payload_valid), .payload_ready(payload_ready),
        .event_entry(event_entry), .event_valid(event_valid), .cancel_irq(cancel_irq));
    ctb_engine_model pm_u (.sys_clk(sys_clk), .rst_n(rst_n), .frame_valid(frame_valid),
        .payload_data(payload_data), .payload_valid(payload_valid), .want(want),
        .payload_ready(payload_ready), .frame_done(frame_done));

    // 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // event pulses last one cycle, so latch them here
    always @(posedge sys_clk) begin
        if (event_valid === 1'b1) begin
            ev <= event_entry;
            ev_count++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [12:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // element of four words starting at ram word wi
    task automatic elem(input int wi, input logic [31:0] w0, w1, d0, d1);
        wr(13'h1000 + 13'(wi * 4), w0);
        wr(13'h1004 + 13'(wi * 4), w1);
        wr(13'h1008 + 13'(wi * 4), d0);
        wr(13'h100c + 13'(wi * 4), d1);
    endtask : elem

    task automatic send(input logic [31:0] idx, input ctb_frame_type e);
        int i;
        wr(REG_TX_REQUEST, idx);
        for (i = 0; i < 20 && frame_valid !== 1'b1; i++) @(posedge sys_clk);
        #1;
        `CHK(frame_valid, 1'b1)
        `CHK(frame_desc, e)
        for (i = 0; i < 60 && frame_valid !== 1'b0; i++) @(posedge sys_clk);
        tick(2);
        `CHK(frame_valid, 1'b0)
    endtask : send

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // whole run is under two hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        error_passive = 1'b0;
        want = 5'h00;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(REG_TX_CANCEL_IRQ_ENABLE, rv); `CHK(rv, TX_CANCEL_IRQ_ENABLE_RESET)
        wr(REG_TX_CANCEL_IRQ_ENABLE, 32'ha5c3_0f69);
        rd(REG_TX_CANCEL_IRQ_ENABLE, rv); `CHK(rv, 32'ha5c3_0f69)
        rd(13'h0f0, rv); `CHK(rv, 32'h0000_0000)
        wr(REG_TX_CANCEL_IRQ_ENABLE, 32'h0000_0020);
        wr(REG_TX_CANCEL, 32'h0000_0006);
        tick(4); `CHK(cancel_irq, 1'b0)
        wr(REG_TX_CANCEL, 32'h0000_0005);
        tick(3); `CHK(cancel_irq, 1'b1)
        rd(REG_CANCEL_DONE, rv); `CHK(rv[6:5], 2'b11)
        wr(REG_CANCEL_DONE, 32'h0000_0060);
        tick(3); `CHK(cancel_irq, 1'b0)
        // two dedicated then two queue slots, 8-byte elements of four words
        wr(REG_TX_BUFFER_CONFIG, 32'h0000_0202);
        wr(REG_TX_ELEMENT_SIZE_CONFIG, 32'h0000_0000);
        elem(12, {3'b000, 11'h123, 18'h0}, 32'ha588_0000, 32'h4433_2211, 32'h8877_6655);
        error_passive <= 1'b1;
        want <= 5'd2;
        exp_f = '{index:5'd3, is_fifo_queue:1'b1, esi:1'b1, extended:1'b0, remote:1'b0,
                  id:{11'h123, 18'h0}, fd_format:1'b0, brs:1'b0, dlc:4'h8, efc:1'b1, marker:8'ha5};
        send(32'h0000_0003, exp_f);
        `CHK(pm_u.got[0], 32'h4433_2211)
        `CHK(pm_u.got[1], 32'h8877_6655)
        `CHK(ev, {8'ha5, 5'd3})
        wr(REG_TX_REQUEST, 32'h0000_0004);
        rd(REG_STATUS, rv); `CHK(rv[9], 1'b1)
        wr(REG_CONTROL, 32'h0000_0001);
        error_passive <= 1'b0;
        want <= 5'd0;
        pm_u.got.delete();
        elem(0, {3'b111, 29'h0abc_def1}, 32'h3c3f_0000, 32'h0102_0304, 32'h0506_0708);
        exp_f = '{index:5'd0, is_fifo_queue:1'b0, esi:1'b1, extended:1'b1, remote:1'b1,
                  id:29'h0abc_def1, fd_format:1'b0, brs:1'b0, dlc:4'hf, efc:1'b0, marker:8'h3c};
        send(32'h0000_0000, exp_f);
        `CHK(pm_u.got.size(), 0)
        `CHK(ev_count, 1)
        // fd data frame in 64-byte elements; sixteen words back the fifo up
        wr(REG_TX_ELEMENT_SIZE_CONFIG, 32'h0000_0007);
        want <= 5'd16;
        elem(18, {3'b010, 29'h1234_5678}, 32'h77bf_0000, 32'hdead_beef, 32'h0000_0000);
        wr(13'h108c, 32'hcafe_f00d);
        exp_f = '{index:5'd1, is_fifo_queue:1'b0, esi:1'b0, extended:1'b1, remote:1'b0,
                  id:29'h1234_5678, fd_format:1'b1, brs:1'b1, dlc:4'hf, efc:1'b1, marker:8'h77};
        send(32'h0000_0001, exp_f);
        `CHK(pm_u.got.size(), 16)
        `CHK(pm_u.got[0], 32'hdead_beef)
        `CHK(pm_u.got[15], 32'hcafe_f00d)
        `CHK(ev, {8'h77, 5'd1})
        // cancel of the busy element drops its payload and its event
        want <= 5'd31;
        wr(REG_TX_REQUEST, 32'h0000_0001);
        tick(8);
        wr(REG_TX_CANCEL, 32'h0000_0001);
        tick(1); `CHK(frame_valid, 1'b0)
        `CHK(payload_valid, 1'b0)
        rd(REG_CANCEL_DONE, rv); `CHK(rv[1], 1'b1)
        `CHK(ev_count, 2)
        close_out();
    end
endmodule : tb
